//--- lane_ctrl_defines.svh
// What this block does
// - latch each received trigger, change on new or on write
// - software writes may overwrite stored trigger pattern
// - clock lane sleep entry force, self-clears
// - clock lane sleep exit force, self-clears
// - clock lane halt force gives stop state
// - data lane sleep entry force, self-clears
// - data lane sleep exit force, self-clears
// - data halt: stop, transmit direction, byte-clock clear
// - turnaround force on lane 0 only
// - data forces hit all lanes; turnaround lane 0
// - per-lane stop flags in bits 15:12
// - per-lane sleep flags in bits 11:8
// - clock lane stop and sleep flags
// - lane 0 direction bit, 1 receiving
// - clock hold after last payload bit
// - clock continues after data lanes leave HS
// - clock leads data lane HS entry
// - leading HS zero before clock start
// - LP-00 prepare before clock lane HS
`ifndef LANE_CTRL_DEFINES_SVH
`define LANE_CTRL_DEFINES_SVH
`define OFS_RX_TRIG 8'h4C
`define OFS_FORCE 8'h50
`define OFS_STATE 8'h54
`define OFS_RX_SEL 8'h58
`define OFS_TIMING 8'h60
`define BIT_CLK_SLEEP_IN 6
`define BIT_CLK_SLEEP_OUT 5
`define BIT_CLK_HALT 4
`define BIT_DL_SLEEP_IN 3
`define BIT_DL_SLEEP_OUT 2
`define BIT_DL_HALT 1
`define BIT_TURN 0
`define POS_DL_HALTED 12
`define POS_DL_SLEEP 8
`define BIT_CLK_HALTED 5
`define BIT_CLK_SLEEPING 4
`define BIT_DIR 0
`define POS_TRAIL 11
`define POS_POST 8
`define POS_PRE 6
`define POS_ZERO 3
`define POS_PREP 0
`define RST_TIMING 14'h1B9B
`define RST_RX_TRIG 8'h00
`endif

//--- lane_ctrl_pkg.sv
package lane_ctrl_pkg;
  typedef enum logic [7:0] {
    CL_STOP = 8'h01,
    CL_PREP = 8'h02,
    CL_ZERO = 8'h04,
    CL_PRE = 8'h08,
    CL_HS = 8'h10,
    CL_POST = 8'h20,
    CL_TRAIL = 8'h40,
    CL_SLEEP = 8'h80
  } clk_lane_state_e;
  typedef logic [3:0] cycles_t;
endpackage

//--- dsi_lane_state_control.sv
`timescale 1ns/1ns
`include "lane_ctrl_defines.svh"
module dsi_lane_state_control #(
  parameter int DATA_LANES = 2
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic byte_clk,
  input wire logic [7:0] rx_trigger_pattern,
  input wire logic rx_trigger_toggle,
  input wire logic peer_turnaround_done,
  input wire logic hs_request,
  input wire logic [DATA_LANES-1:0] data_lane_hs,
  output lane_ctrl_pkg::clk_lane_state_e clk_lane_state,
  output logic clk_lane_hs_drive,
  output logic clk_lane_lp00,
  output logic clk_hs_ready,
  output logic [DATA_LANES-1:0] data_lane_sleep,
  output logic data_lane_halt,
  output logic lane0_turnaround_start,
  output logic lane0_receiving
);
  import lane_ctrl_pkg::*;

  // lane flags and status fields only have room for four lanes
  if (DATA_LANES < 1 || DATA_LANES > 4)
  begin : g_bad_lanes
    $error("DATA_LANES must be 1 to 4");
  end

  // ------------------------------------------------------------
  // code to hclk cycle counts
  // ------------------------------------------------------------
  // reserved codes take the nearest documented value
  function automatic cycles_t trail_cycles(input logic [2:0] c);
    case (c)
      3'h0: trail_cycles = 4'h2;
      3'h1: trail_cycles = 4'h4;
      3'h2: trail_cycles = 4'h6;
      3'h3: trail_cycles = 4'h8;
      default: trail_cycles = 4'hC;
    endcase
  endfunction

  function automatic cycles_t post_cycles(input logic [2:0] c);
    post_cycles = (c == 3'h0) ? 4'h8 : 4'hC;
  endfunction

  function automatic cycles_t zero_cycles(input logic [2:0] c);
    case (c)
      3'h0: zero_cycles = 4'h2;
      3'h1: zero_cycles = 4'h4;
      default: zero_cycles = 4'h8;
    endcase
  endfunction

  function automatic cycles_t prep_cycles(input logic [2:0] c);
    case (c)
      3'h0: prep_cycles = 4'h1;
      3'h1: prep_cycles = 4'h2;
      3'h2: prep_cycles = 4'h4;
      3'h3: prep_cycles = 4'h8;
      default: prep_cycles = 4'hC;
    endcase
  endfunction

  // ------------------------------------------------------------
  // link-side synchronisers
  // ------------------------------------------------------------
  logic [2:0] bclk_sync_r;
  logic [3:0] tog_sync_r;
  logic [7:0] pat_meta_r;
  logic [7:0] pat_sync_r;
  logic [1:0] peer_sync_r;
  logic peer_seen_r;
  logic byte_edge;
  logic trig_new;
  logic peer_done;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bclk_sync_r <= 3'h0;
      tog_sync_r <= 4'h0;
      pat_meta_r <= 8'h00;
      pat_sync_r <= 8'h00;
      peer_sync_r <= 2'h0;
      peer_seen_r <= 1'b0;
    end
    else
    begin
      bclk_sync_r <= {bclk_sync_r[1:0], byte_clk};
      // extra toggle stage lets the pattern settle first
      tog_sync_r <= {tog_sync_r[2:0], rx_trigger_toggle};
      pat_meta_r <= rx_trigger_pattern;
      pat_sync_r <= pat_meta_r;
      peer_sync_r <= {peer_sync_r[0], peer_turnaround_done};
      peer_seen_r <= peer_sync_r[1];
    end
  end

  assign byte_edge = bclk_sync_r[1] & ~bclk_sync_r[2];
  assign trig_new = tog_sync_r[3] ^ tog_sync_r[2];
  assign peer_done = peer_sync_r[1] & ~peer_seen_r;

  // ------------------------------------------------------------
  // AHB-Lite slave
  // ------------------------------------------------------------
  logic wr_pend_r;
  logic rd_pend_r;
  logic [7:0] addr_r;
  logic addr_phase;
  logic wr_force;
  logic wr_trig;
  logic wr_sel;
  logic wr_timing;

  assign addr_phase = hsel & hready & htrans[1];
  assign hresp = 1'b0;
  // reads take one wait state so a just-written value is seen
  assign hreadyout = ~rd_pend_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r <= 8'h00;
    end
    else
    begin
      if (hready)
      begin
        wr_pend_r <= addr_phase & hwrite;
        rd_pend_r <= addr_phase & ~hwrite;
        if (addr_phase)
          addr_r <= haddr;
      end
      else
      begin
        wr_pend_r <= 1'b0;
        rd_pend_r <= 1'b0;
      end
    end
  end

  assign wr_force = wr_pend_r && addr_r == `OFS_FORCE;
  assign wr_trig = wr_pend_r && addr_r == `OFS_RX_TRIG;
  assign wr_sel = wr_pend_r && addr_r == `OFS_RX_SEL;
  assign wr_timing = wr_pend_r && addr_r == `OFS_TIMING;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0] rx_trig_r;
  logic [13:0] timing_r;
  logic rx_sel_r;
  logic [6:0] force_r;
  logic [DATA_LANES-1:0] dl_sleep_r;
  logic dir_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rx_trig_r <= `RST_RX_TRIG;
    else if (trig_new)
      rx_trig_r <= pat_sync_r;
    else if (wr_trig)
      rx_trig_r <= hwdata[7:0];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      timing_r <= `RST_TIMING;
      rx_sel_r <= 1'b0;
    end
    else
    begin
      if (wr_timing)
        timing_r <= hwdata[13:0];
      if (wr_sel)
        rx_sel_r <= hwdata[0];
    end
  end

  // force bits: only ones act, each reads zero after its clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      force_r <= 7'h00;
    else
    begin
      force_r[6:2] <= wr_force ? hwdata[6:2] : 5'h00;
      force_r[0] <= wr_force & hwdata[0];
      // the halt request waits for a byte-clock edge to clear
      if (wr_force && hwdata[`BIT_DL_HALT])
        force_r[`BIT_DL_HALT] <= 1'b1;
      else if (byte_edge)
        force_r[`BIT_DL_HALT] <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // data lane state
  // ------------------------------------------------------------
  logic halt_act;
  assign halt_act = force_r[`BIT_DL_HALT] & byte_edge;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      dl_sleep_r <= '0;
    else if (halt_act)
      dl_sleep_r <= '0;
    else if (force_r[`BIT_DL_SLEEP_IN])
      dl_sleep_r <= '1;
    else if (force_r[`BIT_DL_SLEEP_OUT])
      dl_sleep_r <= '0;
  end

  // lane 0 direction: 1 while the panel owns the lane
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      dir_r <= 1'b0;
    else if (halt_act)
      dir_r <= 1'b0;
    else if (force_r[`BIT_TURN] && !dl_sleep_r[0])
      dir_r <= 1'b1;
    else if (rx_sel_r && !dl_sleep_r[0] && !data_lane_hs[0])
      dir_r <= 1'b1;
    else if (peer_done && !rx_sel_r)
      dir_r <= 1'b0;
  end

  assign data_lane_sleep = dl_sleep_r;
  assign lane0_receiving = dir_r;
  assign lane0_turnaround_start = force_r[`BIT_TURN] & ~dl_sleep_r[0];
  assign data_lane_halt = halt_act;

  // ------------------------------------------------------------
  // clock lane sequencer, one count per hclk cycle
  // ------------------------------------------------------------
  clk_lane_state_e cl_r;
  cycles_t cnt_r;
  logic cnt_done;
  logic data_all_lp;
  logic [1:0] pre_code;

  assign cnt_done = (cnt_r == 4'h1);
  assign data_all_lp = ~|data_lane_hs;
  assign pre_code = timing_r[`POS_PRE +: 2];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cl_r <= CL_STOP;
      cnt_r <= 4'h1;
    end
    else if (force_r[`BIT_CLK_HALT])
    begin
      cl_r <= CL_STOP;
      cnt_r <= 4'h1;
    end
    else
    begin
      if (!cnt_done)
        cnt_r <= cnt_r - 4'h1;
      case (cl_r)
        CL_STOP:
        begin
          if (force_r[`BIT_CLK_SLEEP_IN])
            cl_r <= CL_SLEEP;
          else if (hs_request)
          begin
            cl_r <= CL_PREP;
            cnt_r <= prep_cycles(timing_r[`POS_PREP +: 3]);
          end
        end
        CL_PREP:
          if (cnt_done)
          begin
            cl_r <= CL_ZERO;
            cnt_r <= zero_cycles(timing_r[`POS_ZERO +: 3]);
          end
        CL_ZERO:
          if (cnt_done)
          begin
            cl_r <= CL_PRE;
            cnt_r <= {2'b00, pre_code} + 4'h1;
          end
        CL_PRE:
          if (cnt_done)
            cl_r <= CL_HS;
        CL_HS:
          if (!hs_request && data_all_lp)
          begin
            cl_r <= CL_POST;
            cnt_r <= post_cycles(timing_r[`POS_POST +: 3]);
          end
        CL_POST:
          if (cnt_done)
          begin
            cl_r <= CL_TRAIL;
            cnt_r <= trail_cycles(timing_r[`POS_TRAIL +: 3]);
          end
        CL_TRAIL:
          if (cnt_done)
            cl_r <= CL_STOP;
        CL_SLEEP:
          if (force_r[`BIT_CLK_SLEEP_OUT])
            cl_r <= CL_STOP;
        default:
          cl_r <= CL_STOP;
      endcase
    end
  end

  assign clk_lane_state = cl_r;
  assign clk_lane_lp00 = (cl_r == CL_PREP);
  assign clk_lane_hs_drive = (cl_r == CL_ZERO) | (cl_r == CL_PRE) | (cl_r == CL_HS)
                           | (cl_r == CL_POST) | (cl_r == CL_TRAIL);
  assign clk_hs_ready = (cl_r == CL_HS);

  // ------------------------------------------------------------
  // status and read data
  // ------------------------------------------------------------
  logic [3:0] dl_halted;
  logic [3:0] dl_sleeping;
  logic [31:0] state_word;
  logic [31:0] rd_mux;

  always_comb
  begin
    dl_halted = 4'h0;
    dl_sleeping = 4'h0;
    for (int i = 0; i < DATA_LANES; i++)
    begin
      dl_sleeping[i] = dl_sleep_r[i];
      dl_halted[i] = ~dl_sleep_r[i] & ~data_lane_hs[i] & ~(i == 0 && dir_r);
    end
  end

  always_comb
  begin
    state_word = 32'h0000_0000;
    state_word[`POS_DL_HALTED +: 4] = dl_halted;
    state_word[`POS_DL_SLEEP +: 4] = dl_sleeping;
    state_word[`BIT_CLK_HALTED] = (cl_r == CL_STOP);
    state_word[`BIT_CLK_SLEEPING] = (cl_r == CL_SLEEP);
    state_word[`BIT_DIR] = dir_r;
  end

  always_comb
  begin
    case (addr_r)
      `OFS_RX_TRIG: rd_mux = {24'h00_0000, rx_trig_r};
      `OFS_FORCE: rd_mux = {25'h0, force_r};
      `OFS_STATE: rd_mux = state_word;
      `OFS_RX_SEL: rd_mux = {31'h0, rx_sel_r};
      `OFS_TIMING: rd_mux = {18'h0, timing_r};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (rd_pend_r)
      hrdata <= rd_mux;
  end

endmodule // dsi_lane_state_control

//--- lane_state_monitor.sv
`timescale 1ns/1ns
module lane_state_monitor (
  input wire logic hclk,
  input wire logic hresetn,
  input wire lane_ctrl_pkg::clk_lane_state_e clk_lane_state,
  input wire logic clk_lane_hs_drive,
  input wire logic clk_lane_lp00,
  input wire logic clk_hs_ready,
  input wire logic data_lane_halt,
  input wire logic lane0_turnaround_start,
  input wire logic lane0_receiving
);
  import lane_ctrl_pkg::*;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----------------------------------------
  // clock lane sequence
  // ----------------------------------------
  lp00_prep_a: assert property ($rose(clk_lane_lp00) |-> $past(clk_lane_state) == CL_STOP && clk_lane_state == CL_PREP)
    else $error("lp00 not started from stop");
  ready_hs_a: assert property ($rose(clk_hs_ready) |-> $past(clk_lane_state) == CL_PRE && clk_lane_state == CL_HS)
    else $error("hs ready not after lead time");
  hs_drive_a: assert property ($rose(clk_lane_hs_drive) |-> $past(clk_lane_lp00) && clk_lane_state == CL_ZERO)
    else $error("hs drive not after prepare");
  pre_bound_a: assert property ($rose(clk_lane_state == CL_PRE) |-> ##[1:4] clk_lane_state != CL_PRE)
    else $error("lead time too long");
  post_follow_a: assert property (($past(clk_lane_state) == CL_HS && !(clk_lane_state inside {CL_HS, CL_STOP})) |-> clk_lane_state == CL_POST)
    else $error("hs not followed by post");
  trail_follow_a: assert property (($past(clk_lane_state) == CL_POST && !(clk_lane_state inside {CL_POST, CL_STOP})) |-> clk_lane_state == CL_TRAIL)
    else $error("post not followed by trail");
  // ----------------------------------------
  // data lane forces
  // ----------------------------------------
  turn_pulse_a: assert property (lane0_turnaround_start |=> !lane0_turnaround_start)
    else $error("turnaround pulse too long");
  halt_pulse_a: assert property (data_lane_halt |=> !data_lane_halt)
    else $error("halt pulse too long");
  halt_dir_a: assert property (data_lane_halt |-> ##[0:1] !lane0_receiving)
    else $error("halt left lane receiving");
  cover property (clk_lane_state == CL_TRAIL);
  cover property (lane0_turnaround_start);
  cover property (data_lane_halt);
endmodule // lane_state_monitor

bind dsi_lane_state_control lane_state_monitor u_mon (.hclk(hclk), .hresetn(hresetn), .clk_lane_state(clk_lane_state),
  .clk_lane_hs_drive(clk_lane_hs_drive), .clk_lane_lp00(clk_lane_lp00), .clk_hs_ready(clk_hs_ready),
  .data_lane_halt(data_lane_halt), .lane0_turnaround_start(lane0_turnaround_start), .lane0_receiving(lane0_receiving));

//--- panel_model.sv
`timescale 1ns/1ns
module panel_model (
  output logic byte_clk,
  output logic [7:0] rx_trigger_pattern,
  output logic rx_trigger_toggle,
  output logic peer_turnaround_done
);
  logic link_on;
  // byte clock stands still unless a session is open; odd offset keeps it off the bus clock edges
  initial
  begin
    byte_clk = 1'b0;
    rx_trigger_pattern = 8'h00;
    rx_trigger_toggle = 1'b0;
    peer_turnaround_done = 1'b0;
    link_on = 1'b0;
    #7;
    forever #160 if (link_on) byte_clk = ~byte_clk;
  end
  task automatic link(input logic on);
    link_on = on;
  endtask
  task automatic send_trigger(input logic [7:0] p);
    rx_trigger_pattern = p;
    #100;
    rx_trigger_toggle = ~rx_trigger_toggle;
    #400;
    rx_trigger_pattern = ~p;
  endtask
  task automatic give_back();
    peer_turnaround_done = 1'b1;
    #400;
    peer_turnaround_done = 1'b0;
    #400;
  endtask
endmodule // panel_model

//--- dsi_lane_state_control_test.sv
`timescale 1ns/1ns
module dsi_lane_state_control_test;
  import lane_ctrl_pkg::*;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hs_request = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0, data_lane_hs = 2'h0, data_lane_sleep;
  logic [31:0] hwdata = 32'h0, hrdata, q;
  logic hreadyout, byte_clk, rx_trigger_toggle, peer_turnaround_done, clk_lane_hs_drive, clk_lane_lp00;
  logic clk_hs_ready, data_lane_halt, lane0_turnaround_start, lane0_receiving;
  logic [7:0] rx_trigger_pattern;
  clk_lane_state_e clk_lane_state;
  int n_errors = 0, check_count = 0, n_turn = 0, n_halt = 0, n_lp = 0;
  logic [13:0] cfg [4] = '{14'h0000, 14'h21D4, 14'h0849, 14'h1082};
  int ex [4][5] = '{'{1, 2, 1, 8, 2}, '{12, 8, 4, 12, 12}, '{2, 4, 2, 8, 4}, '{4, 2, 3, 8, 6}};
  always #20 hclk = ~hclk;
  dsi_lane_state_control u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(),
    .hrdata(hrdata), .byte_clk(byte_clk), .rx_trigger_pattern(rx_trigger_pattern),
    .rx_trigger_toggle(rx_trigger_toggle), .peer_turnaround_done(peer_turnaround_done), .hs_request(hs_request),
    .data_lane_hs(data_lane_hs), .clk_lane_state(clk_lane_state), .clk_lane_hs_drive(clk_lane_hs_drive),
    .clk_lane_lp00(clk_lane_lp00), .clk_hs_ready(clk_hs_ready), .data_lane_sleep(data_lane_sleep),
    .data_lane_halt(data_lane_halt), .lane0_turnaround_start(lane0_turnaround_start),
    .lane0_receiving(lane0_receiving));
  panel_model u_panel (.byte_clk(byte_clk), .rx_trigger_pattern(rx_trigger_pattern),
    .rx_trigger_toggle(rx_trigger_toggle), .peer_turnaround_done(peer_turnaround_done));
  always @(posedge hclk)
  begin
    if (lane0_turnaround_start === 1'b1) n_turn++;
    if (data_lane_halt === 1'b1) n_halt++;
    if (clk_lane_lp00 === 1'b1) n_lp++;
  end
  // ----------------------------------------
  // checks and bus cycles
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic chkn(input string what, input int e, input int s);
    check_count++;
    if (s != e)
    begin
      n_errors++;
      $display("ERROR %s expected %0d seen %0d", what, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, q);
  endtask
  task automatic dwell(input clk_lane_state_e st, input int e);
    int n;
    n = 0;
    repeat (40) if (clk_lane_state !== st) @(negedge hclk);
    while (clk_lane_state === st && n < 40)
    begin
      n++;
      @(negedge hclk);
    end
    chkn(st.name(), e, n);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd(8'h4C, 32'h0);
    rd(8'h50, 32'h0);
    rd(8'h54, 32'h3020);
    rd(8'h60, 32'h1B9B);
    rd(8'h70, 32'h0);
  endtask
  task automatic t_trigger();
    u_panel.send_trigger(8'hA5);
    rd(8'h4C, 32'hA5);
    wr(8'h4C, 32'h3C);
    repeat (20) @(posedge hclk);
    rd(8'h4C, 32'h3C);
    u_panel.send_trigger(8'h5A);
    rd(8'h4C, 32'h5A);
  endtask
  task automatic t_sleep();
    wr(8'h50, 32'h40);
    rd(8'h50, 32'h0);
    chk("clock state", CL_SLEEP, clk_lane_state);
    rd(8'h54, 32'h3010);
    wr(8'h50, 32'h0);
    rd(8'h54, 32'h3010);
    wr(8'h50, 32'h20);
    rd(8'h54, 32'h3020);
    wr(8'h50, 32'h08);
    rd(8'h54, 32'h0320);
    chk("lane sleep", 32'h3, {30'h0, data_lane_sleep});
    wr(8'h50, 32'h04);
    rd(8'h54, 32'h3020);
  endtask
  task automatic t_turn();
    wr(8'h50, 32'h01);
    repeat (4) @(posedge hclk);
    chkn("turn pulses", 1, n_turn);
    rd(8'h54, 32'h2021);
    chk("receiving", 32'h1, {31'h0, lane0_receiving});
    u_panel.give_back();
    rd(8'h54, 32'h3020);
    chk("receiving", 32'h0, {31'h0, lane0_receiving});
    wr(8'h50, 32'h01);
    wr(8'h50, 32'h08);
    u_panel.link(1'b1);
    wr(8'h50, 32'h02);
    repeat (40) if (n_halt == 0) @(posedge hclk);
    u_panel.link(1'b0);
    chkn("halt pulses", 1, n_halt);
    rd(8'h54, 32'h3020);
    rd(8'h50, 32'h0);
  endtask
  task automatic t_burst(input int p, input int z, input int c, input int o, input int t);
    int lp0;
    lp0 = n_lp;
    @(posedge hclk);
    hs_request <= 1'b1;
    dwell(CL_PREP, p);
    dwell(CL_ZERO, z);
    chkn("lp00 cycles", p, n_lp - lp0);
    dwell(CL_PRE, c);
    @(posedge hclk);
    data_lane_hs <= 2'h3;
    hs_request <= 1'b0;
    repeat (6) @(posedge hclk);
    chk("clock state", CL_HS, clk_lane_state);
    chk("hs outputs", 32'h3, {29'h0, clk_lane_lp00, clk_lane_hs_drive, clk_hs_ready});
    data_lane_hs <= 2'h0;
    dwell(CL_POST, o);
    dwell(CL_TRAIL, t);
    chk("clock state", CL_STOP, clk_lane_state);
    chk("hs outputs", 32'h0, {29'h0, clk_lane_lp00, clk_lane_hs_drive, clk_hs_ready});
  endtask
  task automatic t_halt_clock();
    @(posedge hclk);
    hs_request <= 1'b1;
    repeat (60) if (clk_lane_state !== CL_HS) @(posedge hclk);
    data_lane_hs <= 2'h3;
    hs_request <= 1'b0;
    wr(8'h50, 32'h10);
    repeat (3) @(posedge hclk);
    chk("clock state", CL_STOP, clk_lane_state);
    data_lane_hs <= 2'h0;
    rd(8'h50, 32'h0);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge hclk);
    n_errors++;
    finish_test();
  end
  initial
  begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_trigger();
    t_sleep();
    t_turn();
    t_burst(8, 8, 3, 12, 8);
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h60, {18'h0, cfg[i]});
      t_burst(ex[i][0], ex[i][1], ex[i][2], ex[i][3], ex[i][4]);
    end
    t_halt_clock();
    finish_test();
  end
endmodule // dsi_lane_state_control_test
